// file: hdl/bsl_consts.svh
// Constants for the boot strap latch: sampling window and strap default levels.
// Assumes a 100 MHz clock; included by bare name.
// What this block does
// R1: The block runs while chip_enable_n_reset is high and is held in reset while it is low; each release starts anew.
// R2: On every startup and reset the block captures its configuration, boot mode included, from the strap pins.
// R3: Exactly three pins are straps: strap_a_boot_select, strap_b_config and strap_c_boot_qualifier.
// R4: Strap A high selects flash boot, A and C both low select download boot; absent drive A reads 1 and C reads 0.
// R5: The board never presents strap A low with strap C high, as that combination is invalid.
// R6: Straps are read during a window of at least 3 ms after chip enable rises, and the board holds them steady.
// R7: Once the straps are taken the pins are released to their normal I/O function.
// R8: Sampled straps and decoded mode are held so later pin changes do not alter them until the next reset.
`ifndef BSL_CONSTS_SVH
`define BSL_CONSTS_SVH
`define BSL_HOLD_MS 3
`define BSL_CLK_KHZ 100000
`define BSL_HOLD_CYCLES (`BSL_HOLD_MS * `BSL_CLK_KHZ)
`define BSL_STRAP_A_DEFAULT 1'b1
`define BSL_STRAP_B_DEFAULT 1'b0
`define BSL_STRAP_C_DEFAULT 1'b0
`endif

// file: hdl/bsl_pkg.sv
// Types shared by the boot strap latch files.
// Assumes bsl_consts.svh is on the include path.
package bsl_pkg;
	typedef enum logic [1:0] {
		BSL_MODE_NONE = 2'h0,
		BSL_MODE_FLASH = 2'h1,
		BSL_MODE_DOWNLOAD = 2'h2,
		BSL_MODE_INVALID = 2'h3
	} bsl_mode_e;
	typedef struct packed {
		logic a;
		logic b;
		logic c;
	} bsl_straps_s;
endpackage

// file: hdl/bsl_decode.sv
// Boot mode decoder: combinational map from strap levels to a mode.
// Assumes its result is only taken while the straps stand steady.
`timescale 1ns/1ns
module bsl_decode (
	input wire bsl_pkg::bsl_straps_s straps,
	output bsl_pkg::bsl_mode_e mode
);
	import bsl_pkg::*;
	wire sel_flash;
	wire sel_download;
	assign sel_flash = straps.a; // see R4
	assign sel_download = !straps.a && !straps.c; // see R4
	// Invalid pair still decoded so firmware can see it, see R5
	assign mode = sel_flash ? BSL_MODE_FLASH : (sel_download ? BSL_MODE_DOWNLOAD : BSL_MODE_INVALID);
endmodule // bsl_decode

// file: hdl/bsl_latch.sv
// Boot strap latch top: times the strap window after chip enable release,
// latches the three straps, decodes boot mode, then hands pins to normal I/O.
// Assumes straps and chip enable are synchronous to clk.
`timescale 1ns/1ns
`include "bsl_consts.svh"
module bsl_latch #(
	parameter int unsigned HOLD_CYCLES = `BSL_HOLD_CYCLES
) (
	input wire clk,
	input wire sys_rst,
	input wire chip_enable_n_reset,
	input wire bsl_pkg::bsl_straps_s strap_in,
	output bsl_pkg::bsl_straps_s straps_held,
	output bsl_pkg::bsl_mode_e boot_mode,
	output logic boot_mode_valid,
	output logic pins_released,
	output logic chip_running
);
	import bsl_pkg::*;

	typedef enum logic [2:0] {
		BSL_ST_RESET = 3'h1,
		BSL_ST_SAMPLE = 3'h2,
		BSL_ST_DONE = 3'h4
	} bsl_state_e;

	localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(HOLD_CYCLES - 1);

	bsl_state_e state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	bsl_straps_s straps_r, straps_nxt;
	bsl_mode_e mode_r, mode_nxt;
	logic valid_r, released_r, running_r;
	bsl_mode_e mode_dec;
	wire in_reset;
	wire window_end;
	bsl_straps_s strap_defaults;

	assign strap_defaults = '{a: `BSL_STRAP_A_DEFAULT, b: `BSL_STRAP_B_DEFAULT, c: `BSL_STRAP_C_DEFAULT};
	assign in_reset = !chip_enable_n_reset; // see R1
	assign window_end = (state_r == BSL_ST_SAMPLE) && (cnt_r == CNT_LAST); // see R6

	bsl_decode u_decode (
		.straps(strap_in),
		.mode(mode_dec)
	);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		straps_nxt = straps_r;
		mode_nxt = mode_r;
		case (state_r)
			BSL_ST_RESET: begin
				cnt_nxt = '0;
				if (!in_reset) begin
					state_nxt = BSL_ST_SAMPLE;
				end
			end
			BSL_ST_SAMPLE: begin
				// Sample at window close so the board's hold time is honoured, see R6
				cnt_nxt = cnt_r + CW'(1);
				if (window_end) begin
					straps_nxt = strap_in; // see R2 see R3
					mode_nxt = mode_dec; // see R4
					state_nxt = BSL_ST_DONE;
				end
			end
			BSL_ST_DONE: begin
				state_nxt = BSL_ST_DONE; // Held until next reset, see R8
			end
			default: begin
				state_nxt = BSL_ST_RESET;
			end
		endcase
		if (in_reset) begin
			// Every reset drops the latch so straps are re-read, see R1 see R2
			state_nxt = BSL_ST_RESET;
			cnt_nxt = '0;
			straps_nxt = strap_defaults;
			mode_nxt = BSL_MODE_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= BSL_ST_RESET;
			cnt_r <= '0;
			straps_r <= '{a: `BSL_STRAP_A_DEFAULT, b: `BSL_STRAP_B_DEFAULT, c: `BSL_STRAP_C_DEFAULT};
			mode_r <= BSL_MODE_NONE;
			valid_r <= 1'b0;
			released_r <= 1'b0;
			running_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			straps_r <= straps_nxt;
			mode_r <= mode_nxt;
			valid_r <= (state_nxt == BSL_ST_DONE); // see R8
			released_r <= (state_nxt == BSL_ST_DONE); // see R7
			running_r <= !in_reset; // see R1
		end
	end

	assign straps_held = straps_r;
	assign boot_mode = mode_r;
	assign boot_mode_valid = valid_r;
	assign pins_released = released_r;
	assign chip_running = running_r;
endmodule // bsl_latch

// file: bench/bsl_chk_sva.sv
// Port checker for bsl_latch.
// Assumes clk rising edge, sys_rst sync high.
`timescale 1ns/1ns
module bsl_chk #(parameter int unsigned HOLD_CYCLES = 8) (
	input wire clk,
	input wire sys_rst,
	input wire chip_enable_n_reset,
	input wire bsl_pkg::bsl_straps_s strap_in,
	input wire bsl_pkg::bsl_straps_s straps_held,
	input wire bsl_pkg::bsl_mode_e boot_mode,
	input wire boot_mode_valid,
	input wire pins_released,
	input wire chip_running
);
	import bsl_pkg::*;
	int unsigned cnt_r;
	// Counts enabled cycles, stops once valid
	always_ff @(posedge clk) cnt_r <= (sys_rst || !chip_enable_n_reset) ? 0 : cnt_r + {31'h0, !boot_mode_valid};
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_run_follow: assert property (!chip_enable_n_reset |=> !chip_running && !boot_mode_valid) else $error("run");
	a_run_high: assert property (chip_enable_n_reset |=> chip_running) else $error("not running");
	a_valid_time: assert property ($rose(boot_mode_valid) |-> cnt_r == HOLD_CYCLES + 1) else $error("early");
	a_valid_due: assert property (cnt_r == HOLD_CYCLES + 1 |-> boot_mode_valid) else $error("late");
	a_take_pins: assert property ($rose(boot_mode_valid) |-> straps_held == $past(strap_in)) else $error("take");
	a_mode_map: assert property (boot_mode_valid |-> boot_mode == (straps_held.a ? BSL_MODE_FLASH :
		straps_held.c ? BSL_MODE_INVALID : BSL_MODE_DOWNLOAD)) else $error("mode");
	a_held_fixed: assert property (boot_mode_valid && $past(boot_mode_valid) |-> $stable(straps_held)) else $error("held");
	a_pins_free: assert property (pins_released == boot_mode_valid) else $error("free");
endmodule // bsl_chk
bind bsl_latch bsl_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (.clk, .sys_rst, .chip_enable_n_reset, .strap_in,
	.straps_held, .boot_mode, .boot_mode_valid, .pins_released, .chip_running);

// file: bench/bsl_board.sv
// Board pulls or a driver on the straps.
// Assumes the bench owns drv and val.
`timescale 1ns/1ns
module bsl_board (
	input wire clk,
	input wire drv,
	input wire bsl_pkg::bsl_straps_s val,
	output bsl_pkg::bsl_straps_s pins
);
	import bsl_pkg::*;
	logic b_r = 1'b0;
	// B has no pull, so it wanders
	always @(posedge clk) b_r <= ~b_r;
	assign pins = drv ? val : {1'b1, b_r, 1'b0};
endmodule // bsl_board

// file: bench/testbench.sv
// Bench for bsl_latch with a board model.
// Assumes a window of 8 cycles.
`timescale 1ns/1ns
module testbench;
	import bsl_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, chip_enable_n_reset = 1'b0, drv = 1'b0;
	logic boot_mode_valid, pins_released, chip_running;
	bsl_straps_s val = 3'h0, strap_in, straps_held;
	bsl_mode_e boot_mode;
	int errors = 0, n_tests = 0, cyc = 0;
	bsl_board board_u (.clk, .drv, .val, .pins(strap_in));
	bsl_latch #(.HOLD_CYCLES(8)) dut_u (.clk, .sys_rst, .chip_enable_n_reset, .strap_in, .straps_held,
		.boot_mode, .boot_mode_valid, .pins_released, .chip_running);
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			final_report();
		end
	end
	task check(input string nm, input logic [3:0] s, input logic [3:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("FAIL %s exp %h seen %h", nm, e, s);
		end
	endtask
	task final_report();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task boot(input logic d, input bsl_straps_s v, input bsl_mode_e m);
		@(negedge clk);
		chip_enable_n_reset = 1'b0;
		drv = d;
		val = v;
		@(negedge clk);
		check("off", {chip_running, boot_mode_valid, boot_mode}, {2'h0, BSL_MODE_NONE});
		chip_enable_n_reset = 1'b1;
		repeat (8) @(negedge clk);
		check("early", {chip_running, pins_released, boot_mode_valid}, 4'h4);
		@(negedge clk);
		check("on", {pins_released, boot_mode_valid, boot_mode}, {2'h3, m});
		val.b = ~v.b;
		repeat (3) @(negedge clk);
		check("held", d ? straps_held : {straps_held.a, 1'b0, straps_held.c}, d ? v : 3'h4);
	endtask
	initial begin
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
		boot(1'b0, 3'h0, BSL_MODE_FLASH);
		boot(1'b1, 3'h5, BSL_MODE_FLASH);
		boot(1'b1, 3'h2, BSL_MODE_DOWNLOAD);
		boot(1'b1, 3'h7, BSL_MODE_FLASH);
		boot(1'b1, 3'h4, BSL_MODE_FLASH);
		final_report();
	end
endmodule // testbench
